// File: verilog/mce_pkg.sv
/*
  constants for the motion command executor subset.
  assumes a host link that delivers parsed 9-byte frames.
*/
// ==========================================================
package mce_pkg;
  // ========================================================
  // opcodes
  localparam logic [7:0] OP_ROTATE_RIGHT = 8'h33;
  localparam logic [7:0] OP_SET_IDX_VAR  = 8'h37;
  localparam logic [7:0] OP_GET_IDX_VAR  = 8'h38;
  localparam logic [7:0] OP_ACCU_TO_VAR  = 8'h39;
  localparam logic [7:0] OP_USER_FN_BASE = 8'h40;
  localparam logic [7:0] OP_USER_FN_LAST = 8'h47;
  localparam logic [7:0] OP_REQ_TARGET   = 8'h8a;
  // ========================================================
  // reply codes and fields
  localparam logic [7:0] ST_OK           = 8'h64;
  localparam logic [7:0] ST_TARGET_EVT   = 8'h80;
  localparam logic [7:0] ST_BAD_CMD      = 8'h02;
  localparam logic [7:0] ST_BAD_CHKSUM   = 8'h01;
  localparam logic [7:0] AXIS_TARGET_VEL = 8'h02;
  localparam logic [7:0] HOST_ADDR       = 8'h02;
  localparam logic [7:0] MODULE_ADDR     = 8'h01;
  localparam logic [7:0] MOTOR_MASK      = 8'h01;
  localparam int         NUM_VARS        = 256;
  localparam logic [7:0] NOTIFY_PERSIST  = 8'h01;
  typedef enum logic [1:0] {
    MCE_MODE_IDLE,
    MCE_MODE_VELOCITY,
    MCE_MODE_POSITION
  } mce_mode_t;
endpackage

// File: verilog/mce_chksum.sv
/*
  checksum over eight frame bytes.
  assumes bytes supplied in frame order, first byte in low bits.
*/
`timescale 1ns/100ps
module mce_chksum (
  // frame bytes
  input  wire logic [63:0] bytes_in,
  // low byte of sum
  output      logic [7:0]  sum
);
  import mce_pkg::*;
  // ========================================================
  // add eight bytes, keep low byte
  logic [7:0] part [0:8];
  assign part[0] = 8'h00;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_add
      assign part[i+1] = part[i] + bytes_in[8*i +: 8];
    end
  endgenerate
  assign sum = part[8];
endmodule

// File: verilog/mce_user_vars.sv
/*
  user variable storage, 256 words of 32 bits in flip-flops.
  assumes single write port and combinational read by index.
*/
`timescale 1ns/100ps
module mce_user_vars (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // write port
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic [7:0]  rd_idx,
  output      logic [31:0] rd_data
);
  import mce_pkg::*;
  logic [31:0] mem [0:NUM_VARS-1];
  // ========================================================
  // storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_VARS; k++) mem[k] <= 32'h0000_0000;
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem[rd_idx];
endmodule

// File: verilog/mce_exec.sv
/*
  command executor: rotate right by accumulator, indexed user
  variables, user function opcodes, target reached notification.
  assumes a framer delivering one whole command per cmd_valid
  pulse and a reply serialiser taking one reply per rep_valid
  while rep_ready is high.
*/
`timescale 1ns/100ps
module mce_exec (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // command in
  input  wire logic             cmd_valid,
  output      logic             cmd_ready,
  input  wire logic [7:0]       cmd_addr,
  input  wire logic [7:0]       cmd_op,
  input  wire logic [7:0]       cmd_type,
  input  wire logic [7:0]       cmd_bank,
  input  wire logic [31:0]      cmd_value,
  input  wire logic [7:0]       cmd_chksum,
  // reply out
  output      logic             rep_valid,
  input  wire logic             rep_ready,
  output      logic [7:0]       rep_status,
  output      logic [7:0]       rep_cmd,
  output      logic [31:0]      rep_value,
  output      logic [7:0]       rep_chksum,
  // interpreter registers
  input  wire logic             x_load,
  input  wire logic [31:0]      x_in,
  output      logic [31:0]      x_reg,
  output      logic [31:0]      accu,
  // user function extension
  input  wire logic [31:0]      uf_value,
  output      logic             uf_start,
  // motion controller
  output      mce_pkg::mce_mode_t axis_mode,
  output      logic             axis_wr,
  output      logic [7:0]       axis_param,
  output      logic [31:0]      axis_data,
  output      logic             dir_right,
  input  wire logic             move_start,
  input  wire logic             target_reached,
  output      logic [1:0]       notify_armed
);
  import mce_pkg::*;

  // ========================================================
  // decode
  function automatic logic is_user_fn(input logic [7:0] op);
    return (op >= OP_USER_FN_BASE) && (op <= OP_USER_FN_LAST);
  endfunction

  logic [7:0]  calc_sum;
  logic        sum_ok;
  logic        take;
  logic        x_in_range;
  logic        op_rot;
  logic        op_siv;
  logic        op_giv;
  logic        op_aiv;
  logic        op_uf;
  logic        op_req;
  logic        op_known;
  logic [31:0] var_rd;
  logic        var_wr;
  logic [31:0] var_wdata;
  logic        evt_pending;
  logic        evt_fire;
  logic        shot_move;
  logic        shot_done;
  logic        evt_hit;
  logic        reply_busy;
  logic [7:0]  rep_sum;

  mce_chksum u_cmd_sum (
    .bytes_in ({cmd_value[7:0], cmd_value[15:8], cmd_value[23:16],
                cmd_value[31:24], cmd_bank, cmd_type, cmd_op,
                cmd_addr}),
    .sum      (calc_sum)
  );

  assign sum_ok     = (calc_sum == cmd_chksum);
  assign cmd_ready  = !reply_busy;
  assign take       = cmd_valid && cmd_ready;
  assign x_in_range = (x_reg[31:8] == 24'h00_0000);
  assign op_rot     = (cmd_op == OP_ROTATE_RIGHT);
  assign op_siv     = (cmd_op == OP_SET_IDX_VAR);
  assign op_giv     = (cmd_op == OP_GET_IDX_VAR);
  assign op_aiv     = (cmd_op == OP_ACCU_TO_VAR);
  assign op_uf      = is_user_fn(cmd_op);
  assign op_req     = (cmd_op == OP_REQ_TARGET);
  assign op_known   = op_rot | op_siv | op_giv | op_aiv | op_uf | op_req;

  // ========================================================
  // user variables, indexed by low byte of x
  assign var_wr    = take && sum_ok && x_in_range
                     && (op_siv || op_aiv);
  assign var_wdata = op_siv ? cmd_value : accu;

  mce_user_vars u_vars (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wr_en   (var_wr),
    .wr_idx  (x_reg[7:0]),
    .wr_data (var_wdata),
    .rd_idx  (x_reg[7:0]),
    .rd_data (var_rd)
  );

  // ========================================================
  // accumulator and x register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      accu  <= 32'h0000_0000;
      x_reg <= 32'h0000_0000;
    end else begin
      if (take && sum_ok && op_giv && x_in_range) begin
        accu <= var_rd;
      end
      if (x_load) begin
        x_reg <= x_in;
      end
    end
  end

  // ========================================================
  // axis control: velocity mode and target velocity write
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      axis_mode  <= MCE_MODE_IDLE;
      axis_wr    <= 1'b0;
      axis_param <= 8'h00;
      axis_data  <= 32'h0000_0000;
      dir_right  <= 1'b0;
    end else begin
      axis_wr <= 1'b0;
      if (take && sum_ok && op_rot) begin
        axis_mode  <= MCE_MODE_VELOCITY;
        axis_wr    <= 1'b1;
        axis_param <= AXIS_TARGET_VEL;
        axis_data  <= accu;
        dir_right  <= 1'b1;
      end else if (move_start) begin
        axis_mode  <= MCE_MODE_POSITION;
      end
    end
  end

  // ========================================================
  // notification arming: bit0 one-shot, bit1 persistent
  // one-shot latches the next move, then ends when that move arrives
  assign shot_done = target_reached && shot_move;
  assign evt_hit   = shot_done || (target_reached && notify_armed[1]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      notify_armed <= 2'b00;
      evt_pending  <= 1'b0;
      shot_move    <= 1'b0;
    end else begin
      if (take && sum_ok && op_req && cmd_value[0]) begin
        shot_move <= 1'b0;
        if (cmd_type == NOTIFY_PERSIST) begin
          notify_armed <= 2'b10;
        end else begin
          notify_armed <= 2'b01;
        end
      end else if (shot_done) begin
        notify_armed <= 2'b00;
        shot_move    <= 1'b0;
      end else if (move_start && notify_armed[0]) begin
        shot_move <= 1'b1;
      end
      // arrival sets, sending clears; set wins
      if (evt_hit) begin
        evt_pending <= 1'b1;
      end else if (evt_fire) begin
        evt_pending <= 1'b0;
      end
    end
  end

  // ========================================================
  // reply builder, command replies before events
  assign evt_fire   = evt_pending && !reply_busy && !take;
  assign reply_busy = rep_valid && !rep_ready;
  assign uf_start   = take && sum_ok && op_uf;

  mce_chksum u_rep_sum (
    .bytes_in ({rep_value[7:0], rep_value[15:8], rep_value[23:16],
                rep_value[31:24], rep_cmd, rep_status, MODULE_ADDR,
                HOST_ADDR}),
    .sum      (rep_sum)
  );
  assign rep_chksum = rep_sum;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rep_valid  <= 1'b0;
      rep_status <= 8'h00;
      rep_cmd    <= 8'h00;
      rep_value  <= 32'h0000_0000;
    end else if (take) begin
      rep_valid <= 1'b1;
      rep_cmd   <= cmd_op;
      if (!sum_ok) begin
        rep_status <= ST_BAD_CHKSUM;
        rep_value  <= 32'h0000_0000;
      end else if (!op_known) begin
        rep_status <= ST_BAD_CMD;
        rep_value  <= 32'h0000_0000;
      end else if (op_req) begin
        rep_status <= ST_OK;
        rep_value  <= {24'h00_0000, cmd_value[7:0] & MOTOR_MASK};
      end else if (op_uf) begin
        rep_status <= ST_OK;
        rep_value  <= uf_value;
      end else begin
        rep_status <= ST_OK;
        rep_value  <= 32'h0000_0000;
      end
    end else if (evt_fire) begin
      rep_valid  <= 1'b1;
      rep_status <= ST_TARGET_EVT;
      rep_cmd    <= OP_REQ_TARGET;
      rep_value  <= {24'h00_0000, MOTOR_MASK};
    end else if (rep_ready) begin
      rep_valid <= 1'b0;
    end
  end
endmodule

// File: tb/mce_exec_properties.sv
/*
  port checker for the command executor.
  assumes it is bound to every mce_exec instance.
*/
`timescale 1ns/100ps
module mce_exec_properties (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // command
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_addr,
  input wire logic [7:0]  cmd_op,
  input wire logic [7:0]  cmd_type,
  input wire logic [7:0]  cmd_bank,
  input wire logic [31:0] cmd_value,
  input wire logic [7:0]  cmd_chksum,
  // reply
  input wire logic        rep_valid,
  input wire logic [7:0]  rep_status,
  input wire logic [7:0]  rep_cmd,
  input wire logic [31:0] rep_value,
  input wire logic [7:0]  rep_chksum,
  // state and motion
  input wire logic [31:0] x_reg,
  input wire logic [31:0] accu,
  input wire logic        uf_start,
  input wire mce_pkg::mce_mode_t axis_mode,
  input wire logic        axis_wr,
  input wire logic [7:0]  axis_param,
  input wire logic [31:0] axis_data,
  input wire logic        dir_right,
  input wire logic        target_reached,
  input wire logic [1:0]  notify_armed
);
  import mce_pkg::*;
  // ==========================================================
  // frame decode: a take with a sound checksum
  logic [7:0] ck;
  logic [7:0] rk;
  logic       good;
  assign ck = cmd_addr + cmd_op + cmd_type + cmd_bank + cmd_value[31:24]
            + cmd_value[23:16] + cmd_value[15:8] + cmd_value[7:0];
  assign rk = 8'h03 + rep_status + rep_cmd + rep_value[31:24]
            + rep_value[23:16] + rep_value[15:8] + rep_value[7:0];
  assign good = cmd_valid && cmd_ready && ck == cmd_chksum;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_reply_take: assert property (cmd_valid && cmd_ready |=> rep_valid)
    else $error("no reply after take");
  a_rotate_vel: assert property (good && cmd_op == OP_ROTATE_RIGHT |=>
    dir_right && axis_mode == MCE_MODE_VELOCITY && axis_param == 8'h02
    && axis_data == $past(accu)) else $error("rotate right wrong");
  a_axis_write: assert property (good && cmd_op == OP_ROTATE_RIGHT |=>
    axis_wr) else $error("no axis parameter write");
  a_accu_keep: assert property (good && cmd_op == OP_ACCU_TO_VAR |=>
    accu == $past(accu)) else $error("accu changed by copy");
  a_range_guard: assert property (good && cmd_op == OP_GET_IDX_VAR
    && x_reg > 32'hff |=> $stable(accu)) else $error("index not ignored");
  a_user_fn: assert property (good && cmd_op >= OP_USER_FN_BASE
    && cmd_op <= OP_USER_FN_LAST |-> uf_start) else $error("no uf start");
  a_notify_mask: assert property (good && cmd_op == OP_REQ_TARGET |=>
    rep_status == ST_OK && rep_cmd == OP_REQ_TARGET
    && rep_value == {31'h0, $past(cmd_value[0])}) else $error("bad ack");
  a_event_reply: assert property (target_reached && notify_armed[1] |->
    ##[1:8] rep_valid && rep_status == ST_TARGET_EVT && rep_cmd == 8'h8a)
    else $error("no target event");
  a_reply_sum: assert property (rep_valid |-> rep_chksum == rk)
    else $error("reply checksum wrong");
endmodule
bind mce_exec mce_exec_properties i_props (.*);

// File: tb/mce_host.sv
/*
  host model: sends command frames and takes replies.
  assumes one shared clock with the executor.
*/
`timescale 1ns/100ps
module mce_host (
  // clock
  input  wire logic        clk_sys,
  // command out
  output      logic        cmd_valid,
  input  wire logic        cmd_ready,
  output      logic [7:0]  cmd_op,
  output      logic [7:0]  cmd_type,
  output      logic [31:0] cmd_value,
  output      logic [7:0]  cmd_chksum,
  // reply in
  input  wire logic        rep_valid,
  output      logic        rep_ready,
  input  wire logic [7:0]  rep_status,
  input  wire logic [7:0]  rep_cmd,
  input  wire logic [31:0] rep_value
);
  logic [47:0] got;
  // idle at time zero
  initial begin
    {cmd_valid, cmd_op, cmd_type, cmd_value, cmd_chksum} = 57'h0;
    rep_ready = 1'b1;
  end
  // ==========================================================
  // one frame, held until taken; bad flips the checksum low bit
  task automatic send(input logic [7:0] op, ty, input logic [31:0] v,
                      input int stall, input logic bad);
    int n;
    @(negedge clk_sys);
    cmd_op = op;
    cmd_type = ty;
    cmd_value = v;
    cmd_chksum = 8'h01 + op + ty + v[31:24] + v[23:16] + v[15:8] + v[7:0]
                 ^ {7'h0, bad};
    cmd_valid = 1'b1;
    n = 0;
    do @(posedge clk_sys); while (!cmd_ready && ++n < 50);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    {cmd_op, cmd_type, cmd_value} = ~{cmd_op, cmd_type, cmd_value};
    rep_ready = (stall == 0);
    repeat (stall) @(negedge clk_sys);
    rep_ready = 1'b1;
    take();
  endtask
  // wait for one reply and keep it
  task automatic take();
    int n;
    n = 0;
    do @(posedge clk_sys); while (!(rep_valid && rep_ready) && ++n < 50);
    // a missing reply leaves unknowns so the next compare trips
    got = (rep_valid && rep_ready) ? {rep_status, rep_cmd, rep_value}
                                   : {48{1'bx}};
  endtask
endmodule

// File: tb/tb.sv
/*
  top bench for the command executor.
  assumes mce_host on the command side; motion inputs driven here.
*/
`timescale 1ns/100ps
module tb;
  import mce_pkg::*;
  logic        clk_sys, nrst, cmd_valid, cmd_ready, rep_valid, rep_ready;
  logic        x_load, uf_start, axis_wr, dir_right, move_start;
  logic        target_reached;
  logic [7:0]  cmd_op, cmd_type, cmd_chksum, rep_status, rep_cmd;
  logic [7:0]  rep_chksum, axis_param;
  logic [31:0] cmd_value, rep_value, x_in, x_reg, accu, uf_value, axis_data;
  logic [1:0]  notify_armed;
  mce_mode_t   axis_mode;
  int          err_count, cmp_count, cyc;
  mce_exec i_dut (.cmd_addr(8'h01), .cmd_bank(8'h00), .*);
  mce_host i_host (.*);
  // clock and hang limit
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [47:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmd(input logic [7:0] op, ty, input logic [31:0] v,
                     input int st, input logic bad, input logic [7:0] es);
    i_host.send(op, ty, v, st, bad);
    chk({40'h0, i_host.got[47:40]}, {40'h0, es});
  endtask
  task automatic setx(input logic [31:0] v);
    @(negedge clk_sys);
    x_load = 1'b1;
    x_in = v;
    @(negedge clk_sys);
    x_load = 1'b0;
  endtask
  // one move; with evt low rep_valid must be low six cycles after arrival
  task automatic reach(input logic evt);
    @(negedge clk_sys);
    move_start = 1'b1;
    @(negedge clk_sys);
    move_start = 1'b0;
    target_reached = 1'b1;
    @(negedge clk_sys);
    target_reached = 1'b0;
    if (evt) begin
      i_host.take();
    end else begin
      repeat (6) @(negedge clk_sys);
      chk({47'h0, rep_valid}, 48'h0);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    nrst = 1'b0;
    {x_load, move_start, target_reached, x_in, uf_value} = 67'h0;
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    chk({accu, 6'h0, notify_armed, 7'h0, cmd_ready}, 48'h1);
    setx(32'h5);
    cmd(OP_SET_IDX_VAR, 8'h0, 32'h1234abcd, 0, 0, ST_OK);
    cmd(OP_GET_IDX_VAR, 8'h0, 32'h0, 0, 0, ST_OK);
    setx(32'h9);
    cmd(OP_ACCU_TO_VAR, 8'h0, 32'h0, 3, 0, ST_OK);
    setx(32'h100);
    cmd(OP_SET_IDX_VAR, 8'h0, 32'h55, 0, 0, ST_OK);
    cmd(OP_GET_IDX_VAR, 8'h0, 32'h0, 0, 0, ST_OK);
    chk({16'h0, accu}, 48'h1234abcd);
    setx(32'h5);
    cmd(OP_SET_IDX_VAR, 8'h0, 32'h0, 0, 0, ST_OK);
    cmd(OP_GET_IDX_VAR, 8'h0, 32'h0, 0, 0, ST_OK);
    chk({16'h0, accu}, 48'h0);
    setx(32'h9);
    cmd(OP_GET_IDX_VAR, 8'h0, 32'h0, 0, 0, ST_OK);
    chk({16'h0, accu}, 48'h1234abcd);
    $display("test vars done");
    cmd(OP_ROTATE_RIGHT, 8'h5, 32'hffff, 2, 0, ST_OK);
    chk({37'h0, dir_right, axis_mode, axis_param},
        {37'h0, 1'b1, MCE_MODE_VELOCITY, AXIS_TARGET_VEL});
    chk({16'h0, axis_data}, 48'h1234abcd);
    cmd(OP_ACCU_TO_VAR, 8'h0, 32'h0, 0, 1, ST_BAD_CHKSUM);
    cmd(8'h10, 8'h0, 32'h0, 0, 0, ST_BAD_CMD);
    $display("test rotate done");
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      uf_value = 32'hc0de0000 + 32'(i);
      cmd(OP_USER_FN_BASE + 8'(i), 8'h0, 32'h0, 0, 0, ST_OK);
      chk(i_host.got[31:0], uf_value);
    end
    $display("test user fn done");
    cmd(OP_REQ_TARGET, 8'h1, 32'h1, 0, 0, ST_OK);
    chk(i_host.got, {ST_OK, OP_REQ_TARGET, 32'h1});
    chk({46'h0, notify_armed}, 48'h2);
    repeat (2) begin
      reach(1'b1);
      chk(i_host.got, {ST_TARGET_EVT, OP_REQ_TARGET, 32'h1});
    end
    chk({46'h0, notify_armed}, 48'h2);
    chk({46'h0, axis_mode}, {46'h0, MCE_MODE_POSITION});
    cmd(OP_REQ_TARGET, 8'h0, 32'h1, 0, 0, ST_OK);
    chk({46'h0, notify_armed}, 48'h1);
    reach(1'b1);
    chk(i_host.got, {ST_TARGET_EVT, OP_REQ_TARGET, 32'h1});
    reach(1'b0);
    chk({46'h0, notify_armed}, 48'h0);
    chk({16'h0, x_reg}, 48'h9);
    $display("test notify done");
    end_of_test();
  end
endmodule
